/* File: hdl/eac_pkg.sv */
// Constants, register map and helpers for the EEPROM access control block.
// Assumes a single 125 MHz clock and a 1 MHz write timebase derived from it.
package eac_pkg;
    // Clock and write timing
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int OSC_PERIOD_PS    = 1000000;
    localparam int OSC_DIV          = OSC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int WRITE_OSC_CYCLES = 8448;
    localparam int MWE_WINDOW       = 4;
    localparam int STALL_WRITE      = 2;
    localparam int STALL_READ       = 4;
    // Array geometry
    localparam int ADDR_W    = 10;
    localparam int DATA_W    = 8;
    localparam int MEM_DEPTH = 1024;
    // Core-side I/O locations
    localparam logic [1:0] IO_CTRL    = 2'h0;
    localparam logic [1:0] IO_DATA    = 2'h1;
    localparam logic [1:0] IO_ADDR_LO = 2'h2;
    localparam logic [1:0] IO_ADDR_HI = 2'h3;
    // Control register bits
    localparam int CTRL_RIE = 3;
    localparam int CTRL_MWE = 2;
    localparam int CTRL_WS  = 1;
    localparam int CTRL_RS  = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [9:0] ADDR_RST = 10'h000;
    // Controller APB map
    localparam logic [7:0] REG_ADDR   = 8'h00;
    localparam logic [7:0] REG_WDATA  = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_CFG    = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CMD_READ  = 0;
    localparam int CMD_WRITE = 1;
    localparam int CFG_RIE   = 0;
    localparam int CFG_GIE   = 1;
    localparam int CFG_SLEEP = 2;
    localparam int ST_BUSY   = 0;
    localparam int ST_WPEND  = 1;
    localparam int ST_IRQ    = 2;
    localparam int ST_STALL  = 3;
    localparam int ST_RDATA  = 8;
    localparam logic [2:0] CFG_RST = 3'h0;

    function automatic logic [7:0] ctrl_byte(input logic rie, input logic mwe,
                                             input logic ws, input logic rs);
        ctrl_byte = {4'h0, rie, mwe, ws, rs};
    endfunction
endpackage

/* File: hdl/eac_io_if.sv */
// Internal I/O link between the CPU core and the EEPROM access block.
// Assumes both ends share pclk; the testbench instantiates and joins them.
`timescale 1ns/10ps
interface eac_io_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic [1:0] io_addr;
    logic       io_wr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       stall;
    logic       irq;
    logic       global_ie;
    logic       self_program_enable;
    logic       sleep_pdown;

    modport dev (
        input  pclk, presetn, io_addr, io_wr, io_wdata, global_ie,
        input  self_program_enable, sleep_pdown,
        output io_rdata, stall, irq
    );
    modport cpu (
        input  pclk, presetn, io_rdata, stall, irq,
        output io_addr, io_wr, io_wdata, global_ie, self_program_enable, sleep_pdown
    );
endinterface

/* File: hdl/eac_write_engine.sv */
// Self-timed EEPROM write engine: 1 MHz enable and write-length counter.
// Assumes por_n is a power-on reset only, so system resets leave it running.
`timescale 1ns/10ps
module eac_write_engine #(
    parameter int OSC_DIV     = eac_pkg::OSC_DIV,
    parameter int WRITE_TICKS = eac_pkg::WRITE_OSC_CYCLES,
    parameter int AW          = eac_pkg::ADDR_W,
    parameter int DW          = eac_pkg::DATA_W
) (
    input  wire logic          pclk,
    input  wire logic          por_n,
    input  wire logic          start,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [DW-1:0] data_in,
    output logic               busy_q,
    output logic               done_q,
    output logic [AW-1:0]      addr_q,
    output logic [DW-1:0]      data_q
);
    localparam int DIVW = $clog2(OSC_DIV + 1);
    localparam int TW   = $clog2(WRITE_TICKS + 1);
    localparam logic [DIVW-1:0] DIV_LAST  = DIVW'(OSC_DIV - 1);
    localparam logic [TW-1:0]   TICK_LAST = TW'(WRITE_TICKS - 1);

    logic [DIVW-1:0] div_q;
    logic [TW-1:0]   tick_q;
    logic            osc_tick;
    logic            last;

    assign osc_tick = busy_q && (div_q == DIV_LAST);
    assign last     = osc_tick && (tick_q == TICK_LAST);

    // 1 MHz enable, only while writing
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n)
            div_q <= '0;
        else if (!busy_q || osc_tick)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n)
            tick_q <= '0;
        else if (start)
            tick_q <= '0;
        else if (osc_tick)
            tick_q <= tick_q + 1'b1;
    end

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= start | (busy_q & ~last);
            done_q <= last;
        end
    end

    // Target held for the whole write
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            addr_q <= '0;
            data_q <= '0;
        end else if (start) begin
            addr_q <= addr_in;
            data_q <= data_in;
        end
    end
endmodule

/* File: hdl/eac_device.sv */
// EEPROM access block: control, address and data registers plus byte array.
// Assumes a CPU core on eac_io_if and a power-on reset separate from presetn.
//
// How it works
// R1: Control bits 7..4 read as zero.
// R2: Ready request while enabled, global on, no write.
// R3: Strobe within four cycles of enable writes.
// R4: Strobe without master enable is ignored.
// R5: Master enable self-clears after four cycles.
// R6: Strobe programs data byte at held address.
// R7: Software: poll, load, enable, then strobe.
// R8: No write start while flash self-programming.
// R9: Software keeps interrupts off during sequence.
// R10: Strobe stays one until write completes.
// R11: Write start stalls core two cycles.
// R12: Read strobe loads data, stalls four.
// R13: During write, reads and address frozen.
// R14: Software polls strobe before reading.
// R15: Write lasts 8448 ticks of 1 MHz.
// R16: Power-down keeps write and oscillator running.
// R17: Software finishes writes before power-down.
// R18: System reset does not abort write.
// R19: Ten-bit linear byte address, 0 to 1023.
// R20: Data register feeds writes, receives reads.
// R21: Master enable window is a down-counter.
`timescale 1ns/10ps
module eac_device #(
    parameter int OSC_DIV     = eac_pkg::OSC_DIV,
    parameter int WRITE_TICKS = eac_pkg::WRITE_OSC_CYCLES,
    parameter int DEPTH       = eac_pkg::MEM_DEPTH
) (
    eac_io_if.dev     bus,
    input  wire logic por_n,
    output logic      osc_run_q
);
    localparam int AW = eac_pkg::ADDR_W;
    localparam int DW = eac_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] addr_q;
    logic [DW-1:0] data_q;
    logic          rie_q;
    logic [2:0]    mwe_cnt_q;
    logic [2:0]    mwe_cnt_d;
    logic          mwe_q;
    logic [2:0]    stall_cnt_q;
    logic          stall_q;
    logic          irq_q;
    logic [DW-1:0] rdata_q;
    logic          osc_keep_q;
    logic          busy;
    logic          done;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          ctrl_wr;
    logic          mwe_load;
    logic          wr_start;
    logic          rd_go;
    logic          addr_lo_wr;
    logic          addr_hi_wr;
    logic [7:0]    ctrl_view;

    assign bus.io_rdata = rdata_q;
    assign bus.stall    = stall_q;
    assign bus.irq      = irq_q;

    ////////////////////////////////////////////////////////////////////
    // Access decode
    ////////////////////////////////////////////////////////////////////
    assign ctrl_wr = bus.io_wr && (bus.io_addr == eac_pkg::IO_CTRL);

    // Window opens only when strobe is written zero alongside
    assign mwe_load = ctrl_wr
                   && bus.io_wdata[eac_pkg::CTRL_MWE]
                   && !bus.io_wdata[eac_pkg::CTRL_WS];

    assign wr_start = ctrl_wr
                   && bus.io_wdata[eac_pkg::CTRL_WS]
                   && mwe_q                      // R3 R4
                   && !busy
                   && !bus.self_program_enable;  // R8

    assign rd_go = ctrl_wr
                && bus.io_wdata[eac_pkg::CTRL_RS]
                && !busy;                        // R13

    assign addr_lo_wr = bus.io_wr
                     && (bus.io_addr == eac_pkg::IO_ADDR_LO)
                     && !busy;                   // R13
    assign addr_hi_wr = bus.io_wr
                     && (bus.io_addr == eac_pkg::IO_ADDR_HI)
                     && !busy;                   // R13

    ////////////////////////////////////////////////////////////////////
    // Write engine
    ////////////////////////////////////////////////////////////////////
    // Power-on reset only, so a system reset lets the write finish
    eac_write_engine #(
        .OSC_DIV     (OSC_DIV),
        .WRITE_TICKS (WRITE_TICKS),
        .AW          (AW),
        .DW          (DW)
    ) eac_write_engine_inst (
        .pclk    (bus.pclk),
        .por_n   (por_n),                        // R18
        .start   (wr_start),                     // R6
        .addr_in (addr_q),
        .data_in (data_q),                       // R20
        .busy_q  (busy),                         // R10 R15
        .done_q  (done),
        .addr_q  (wr_addr),
        .data_q  (wr_data)
    );

    // Byte array, no reset
    always_ff @(posedge bus.pclk) begin
        if (done)
            mem[wr_addr] <= wr_data;             // R6
    end

    ////////////////////////////////////////////////////////////////////
    // Address and data registers
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn)
            addr_q <= eac_pkg::ADDR_RST;
        else if (addr_lo_wr)
            addr_q[7:0] <= bus.io_wdata;         // R19
        else if (addr_hi_wr)
            addr_q[AW-1:8] <= bus.io_wdata[AW-9:0];
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn)
            data_q <= eac_pkg::DATA_RST;
        else if (rd_go)
            data_q <= mem[addr_q];               // R12 R20
        else if (bus.io_wr && bus.io_addr == eac_pkg::IO_DATA)
            data_q <= bus.io_wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // Control register
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn)
            rie_q <= eac_pkg::CTRL_RST[eac_pkg::CTRL_RIE];
        else if (ctrl_wr)
            rie_q <= bus.io_wdata[eac_pkg::CTRL_RIE];
    end

    // Down-counter holding the master enable open
    always_comb begin
        if (mwe_load)
            mwe_cnt_d = 3'(eac_pkg::MWE_WINDOW); // R21
        else if (mwe_cnt_q != 3'h0)
            mwe_cnt_d = mwe_cnt_q - 3'h1;
        else
            mwe_cnt_d = 3'h0;
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            mwe_cnt_q <= 3'h0;
            mwe_q     <= 1'b0;
        end else begin
            mwe_cnt_q <= mwe_cnt_d;              // R21
            mwe_q     <= (mwe_cnt_d != 3'h0);    // R5
        end
    end

    assign ctrl_view = eac_pkg::ctrl_byte(rie_q, mwe_q, busy, 1'b0); // R1 R10

    ////////////////////////////////////////////////////////////////////
    // Read-back path, one cycle behind the address
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn)
            rdata_q <= 8'h00;
        else begin
            case (bus.io_addr)
                eac_pkg::IO_CTRL:    rdata_q <= ctrl_view;
                eac_pkg::IO_DATA:    rdata_q <= data_q;
                eac_pkg::IO_ADDR_LO: rdata_q <= addr_q[7:0];
                eac_pkg::IO_ADDR_HI: rdata_q <= {6'h00, addr_q[AW-1:8]};
                default:             rdata_q <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core stall
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            stall_cnt_q <= 3'h0;
            stall_q     <= 1'b0;
        end else if (wr_start) begin
            stall_cnt_q <= 3'(eac_pkg::STALL_WRITE); // R11
            stall_q     <= 1'b1;
        end else if (rd_go) begin
            stall_cnt_q <= 3'(eac_pkg::STALL_READ);  // R12
            stall_q     <= 1'b1;
        end else if (stall_cnt_q != 3'h0) begin
            stall_cnt_q <= stall_cnt_q - 3'h1;
            stall_q     <= (stall_cnt_q != 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ready interrupt request
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn)
            irq_q <= 1'b0;
        else
            irq_q <= rie_q && bus.global_ie && !busy; // R2
    end

    ////////////////////////////////////////////////////////////////////
    // Power-down interplay
    ////////////////////////////////////////////////////////////////////
    // Sleep entered mid-write leaves the timebase running until wake
    always_ff @(posedge bus.pclk or negedge por_n) begin
        if (!por_n)
            osc_keep_q <= 1'b0;
        else if (!bus.sleep_pdown)
            osc_keep_q <= 1'b0;
        else if (busy)
            osc_keep_q <= 1'b1;                  // R16
    end

    always_ff @(posedge bus.pclk or negedge por_n) begin
        if (!por_n)
            osc_run_q <= 1'b0;
        else
            osc_run_q <= busy | osc_keep_q;      // R16
    end
endmodule

/* File: hdl/eac_host.sv */
// Core-side controller: APB register slave that runs EEPROM sequences.
// Assumes the device end on eac_io_if and an APB master on the user side.
`timescale 1ns/10ps
module eac_host (
    eac_io_if.cpu     bus,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]     prdata_q,
    output logic            pready_q,
    output logic            pslverr_q,
    input  wire logic       flash_busy
);
    typedef enum {H_IDLE, H_POLL, H_PCHK, H_ALO, H_AHI, H_DAT, H_MWE, H_WS, H_RS,
                  H_STALL, H_RGET, H_RSMP} eac_hstate_e;
    typedef enum {OP_NONE, OP_RD, OP_WR} eac_op_e;

    eac_hstate_e st_q, st_d;
    eac_op_e     op_q;
    logic [9:0]  addr_q;
    logic [7:0]  wdata_q, rbyte_q;
    logic [2:0]  cfg_q;
    logic        wpend_q, gie_q, sleep_q, spm_q, io_wr_q;
    logic [1:0]  io_addr_q;
    logic [7:0]  io_wdata_q;
    logic        apb_wr, cmd_rd, cmd_wr, rie;

    assign apb_wr = psel && penable && pready_q && pwrite;
    assign cmd_rd = apb_wr && paddr == eac_pkg::REG_CMD && pwdata[eac_pkg::CMD_READ];
    assign cmd_wr = apb_wr && paddr == eac_pkg::REG_CMD && pwdata[eac_pkg::CMD_WRITE];
    assign rie    = cfg_q[eac_pkg::CFG_RIE];
    assign bus.io_wr               = io_wr_q;
    assign bus.io_addr             = io_addr_q;
    assign bus.io_wdata            = io_wdata_q;
    assign bus.global_ie           = gie_q;
    assign bus.sleep_pdown         = sleep_q;
    assign bus.self_program_enable = spm_q;

    ////////////////////////////////////////////////////////////////////
    // APB slave
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && paddr != eac_pkg::REG_ADDR && paddr != eac_pkg::REG_WDATA
                      && paddr != eac_pkg::REG_CMD && paddr != eac_pkg::REG_CFG
                      && paddr != eac_pkg::REG_STATUS;
            case (paddr)
                eac_pkg::REG_ADDR:   prdata_q <= {22'h0, addr_q};
                eac_pkg::REG_WDATA:  prdata_q <= {24'h0, wdata_q};
                eac_pkg::REG_CFG:    prdata_q <= {29'h0, cfg_q};
                eac_pkg::REG_STATUS: prdata_q <= {16'h0, rbyte_q, 4'h0, bus.stall, bus.irq,
                                                  wpend_q, st_q != H_IDLE};
                default:             prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            addr_q  <= eac_pkg::ADDR_RST;
            wdata_q <= eac_pkg::DATA_RST;
            cfg_q   <= eac_pkg::CFG_RST;
        end else if (apb_wr) begin
            if (paddr == eac_pkg::REG_ADDR && st_q == H_IDLE)
                addr_q <= pwdata[9:0];
            if (paddr == eac_pkg::REG_WDATA && st_q == H_IDLE)
                wdata_q <= pwdata[7:0];
            if (paddr == eac_pkg::REG_CFG)
                cfg_q <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        case (st_q)
            H_IDLE:  if (cmd_rd || cmd_wr || wpend_q) st_d = H_POLL;
            H_POLL:  st_d = H_PCHK;
            H_PCHK:  if (bus.io_rdata[eac_pkg::CTRL_WS] || (op_q == OP_WR && flash_busy))
                         st_d = H_POLL;                  // R7 R8 R14
                     else if (op_q == OP_NONE)
                         st_d = H_IDLE;
                     else
                         st_d = H_ALO;
            H_ALO:   st_d = H_AHI;
            H_AHI:   st_d = (op_q == OP_WR) ? H_DAT : H_RS;
            H_DAT:   st_d = H_MWE;
            H_MWE:   st_d = H_WS;                        // R7
            H_WS:    st_d = H_STALL;
            H_RS:    st_d = H_STALL;
            H_STALL: if (!bus.stall) st_d = (op_q == OP_RD) ? H_RGET : H_IDLE; // R11 R12
            H_RGET:  st_d = H_RSMP;
            H_RSMP:  st_d = H_IDLE;
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            st_q <= H_IDLE;
            op_q <= OP_NONE;
        end else begin
            st_q <= st_d;
            if (st_q == H_IDLE)
                op_q <= cmd_wr ? OP_WR : (cmd_rd ? OP_RD : OP_NONE);
        end
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            io_wr_q    <= 1'b0;
            io_addr_q  <= eac_pkg::IO_CTRL;
            io_wdata_q <= 8'h00;
        end else begin
            io_wr_q    <= st_d inside {H_ALO, H_AHI, H_DAT, H_MWE, H_WS, H_RS};
            io_wdata_q <= 8'h00;
            io_addr_q  <= eac_pkg::IO_CTRL;
            case (st_d)
                H_ALO: begin
                    io_addr_q  <= eac_pkg::IO_ADDR_LO;
                    io_wdata_q <= addr_q[7:0];
                end
                H_AHI: begin
                    io_addr_q  <= eac_pkg::IO_ADDR_HI;
                    io_wdata_q <= {6'h00, addr_q[9:8]};
                end
                H_DAT: begin
                    io_addr_q  <= eac_pkg::IO_DATA;
                    io_wdata_q <= wdata_q;
                end
                H_MWE:  io_wdata_q <= eac_pkg::ctrl_byte(rie, 1'b1, 1'b0, 1'b0); // R7
                H_WS:   io_wdata_q <= eac_pkg::ctrl_byte(rie, 1'b0, 1'b1, 1'b0); // R6
                H_RS:   io_wdata_q <= eac_pkg::ctrl_byte(rie, 1'b0, 1'b0, 1'b1);
                H_RGET: io_addr_q  <= eac_pkg::IO_DATA;
                H_RSMP: io_addr_q  <= eac_pkg::IO_DATA;
                default: io_addr_q <= eac_pkg::IO_CTRL;
            endcase
        end
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            wpend_q <= 1'b0;
            rbyte_q <= 8'h00;
            gie_q   <= 1'b0;
            sleep_q <= 1'b0;
            spm_q   <= 1'b0;
        end else begin
            if (st_q == H_PCHK)
                wpend_q <= bus.io_rdata[eac_pkg::CTRL_WS];
            else if (st_q == H_WS)
                wpend_q <= 1'b1;
            if (st_q == H_RSMP)
                rbyte_q <= bus.io_rdata;
            gie_q   <= cfg_q[eac_pkg::CFG_GIE] && st_d == H_IDLE;            // R9
            sleep_q <= cfg_q[eac_pkg::CFG_SLEEP] && !wpend_q && st_d == H_IDLE; // R17
            spm_q   <= flash_busy;
        end
    end
endmodule

/* File: verification/eac_props.sv */
// Checker for the link between the core controller and the EEPROM block.
// Assumes the bench wires it beside the interface that joins both ends.
`timescale 1ns/10ps
module eac_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [1:0] io_addr,
    input wire logic       io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       stall,
    input wire logic       irq,
    input wire logic       global_ie
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_cmd;
    logic wr_cmd;
    assign rd_cmd = io_wr && io_addr == eac_pkg::IO_CTRL && io_wdata[0];
    assign wr_cmd = io_wr && io_addr == eac_pkg::IO_CTRL && io_wdata[1];
    ////////////////////////////////////////////////////////////////////////////
    a_reserved_read_zero: assert property ($past(io_addr) == 2'h0 |-> io_rdata[7:4] == 4'h0)
        else $error("control high bits not zero");
    a_read_stall_four: assert property ($rose(stall) && ($past(rd_cmd) || $past(rd_cmd, 2))
        |-> stall[*4] ##1 !stall) else $error("read stall not four cycles");
    a_write_stall_two: assert property ($rose(stall) && ($past(wr_cmd) || $past(wr_cmd, 2))
        |-> stall[*2] ##1 !stall) else $error("write stall not two cycles");
    a_stall_has_cause: assert property ($rose(stall) |-> $past(rd_cmd || wr_cmd)
        || $past(rd_cmd || wr_cmd, 2)) else $error("stall without strobe");
    a_stall_upper_bound: assert property (stall[*4] |=> !stall) else $error("stall too long");
    a_no_access_stalled: assert property (stall && $past(stall) |-> !io_wr)
        else $error("core access during stall");
    a_irq_needs_global: assert property (irq |-> $past(global_ie)) else $error("irq without global");
    a_irq_idle_only: assert property ($past(io_addr) == 2'h0 && io_rdata[1] |-> !irq)
        else $error("irq while write busy");
    c_stall_seen: cover property ($rose(stall));
    c_irq_seen: cover property ($rose(irq));
    c_write_cmd: cover property (wr_cmd);
endmodule

/* File: verification/eeprom_access_control_bench.sv */
// Self-checking bench: both ends joined, APB master drives the controller.
// Assumes shortened write timing via OSC_DIV 3 and WRITE_TICKS 4.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module eeprom_access_control_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        por_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        flash_busy = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_q;
    logic [31:0] rd;
    logic [31:0] seed = 32'h64DF4F35;
    logic        pready_q;
    logic        pslverr_q;
    logic        osc_run_q;
    logic        err;
    logic [7:0]  mem [int];
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    always #4 pclk = ~pclk;
    eac_io_if bus (.pclk(pclk), .presetn(presetn));
    eac_device #(.OSC_DIV(3), .WRITE_TICKS(4)) eac_device_inst (.bus(bus.dev), .por_n(por_n),
        .osc_run_q(osc_run_q));
    eac_host eac_host_inst (.bus(bus.cpu), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .flash_busy(flash_busy));
    eac_props eac_props_inst (.pclk(bus.pclk), .presetn(bus.presetn), .io_addr(bus.io_addr),
        .io_wr(bus.io_wr), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata), .stall(bus.stall),
        .irq(bus.irq), .global_ie(bus.global_ie));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle;
        do apb(1'b0, eac_pkg::REG_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
    endtask
    task automatic wr_byte(input logic [9:0] a, input logic [7:0] d);
        wait_idle();
        apb(1'b1, eac_pkg::REG_ADDR, {22'h0, a});
        apb(1'b1, eac_pkg::REG_WDATA, {24'h0, d});
        apb(1'b1, eac_pkg::REG_CMD, 32'h2);
        mem[a] = d;
    endtask
    task automatic chk_byte(input logic [9:0] a);
        wait_idle();
        apb(1'b1, eac_pkg::REG_ADDR, {22'h0, a});
        apb(1'b1, eac_pkg::REG_CMD, 32'h1);
        wait_idle();
        `CHK("read byte", mem[a], rd[15:8])
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        apb(1'b0, eac_pkg::REG_STATUS, 32'h0);
        `CHK("status after reset", 3'h0, rd[2:0])
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        wr_byte(10'h000, 8'hA5);
        wr_byte(10'h3FF, 8'h5A);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr_byte(seed[9:0], seed[17:10]);
        end
        foreach (mem[k]) chk_byte(k[9:0]);
        flash_busy <= 1'b1;
        wr_byte(10'h155, 8'h3C);
        repeat (30) @(posedge pclk);
        apb(1'b0, eac_pkg::REG_STATUS, 32'h0);
        `CHK("held while self programming", 2'h1, rd[1:0])
        flash_busy <= 1'b0;
        chk_byte(10'h155);
        wr_byte(10'h2AA, 8'hC3);
        repeat (10) @(posedge pclk);
        `CHK("timebase during write", 1'b1, osc_run_q)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        chk_byte(10'h2AA);
        apb(1'b1, eac_pkg::REG_CFG, 32'h3);
        chk_byte(10'h000);
        repeat (3) @(posedge pclk);
        `CHK("irq enabled", 1'b1, bus.irq)
        apb(1'b1, eac_pkg::REG_CFG, 32'h6);
        chk_byte(10'h3FF);
        repeat (3) @(posedge pclk);
        `CHK("irq masked", 1'b0, bus.irq)
        `CHK("timebase stopped", 1'b0, osc_run_q)
        report_and_stop();
    end
endmodule
